// *** inc/pad_ctrl_pkg.sv ***
/*
  Package for the port pad control block: register offsets, reset values, bus widths and carrier structs.
  Assumes an 8-bit port reached over a classic Wishbone slave with 32-bit data.
*/
`default_nettype none
package pad_ctrl_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned SEL_WIDTH  = 4;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_WIDTH-1:0] PULLUP_OFFSET = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] SLEW_OFFSET   = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] DRIVE_OFFSET  = 4'h8;
  localparam logic [ADDR_WIDTH-1:0] FILTER_OFFSET = 4'hc;

  // ==========================================================================
  // Reset values
  localparam logic [PIN_COUNT-1:0] PULLUP_RESET = 8'h00;
  localparam logic [PIN_COUNT-1:0] SLEW_RESET   = 8'h00;
  localparam logic [PIN_COUNT-1:0] DRIVE_RESET  = 8'h00;
  localparam logic [PIN_COUNT-1:0] FILTER_RESET = 8'hff;

  // Read data for an unmapped address.
  localparam logic [DATA_WIDTH-1:0] UNMAPPED_DATA = 32'h00000000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [ADDR_WIDTH-1:0] adr;
    logic [SEL_WIDTH-1:0]  sel;
    logic [DATA_WIDTH-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] pullup_on;
    logic [PIN_COUNT-1:0] slew_limit_on;
    logic [PIN_COUNT-1:0] high_drive_on;
    logic [PIN_COUNT-1:0] filter_on;
  } pad_ctrl_t;
endpackage
`default_nettype wire

// *** src/pad_byte_reg.sv ***
/*
  One 8-bit software register with a byte-lane write strobe.
  Assumes the write strobe is already qualified by the bus decode and clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_byte_reg #(
  parameter int unsigned             WIDTH      = 8,
  parameter logic [WIDTH-1:0]        RESET_VALUE = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] value
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  // ==========================================================================
  // Storage
  always_comb begin
    value_next = value_reg;
    if (wr_en) begin
      value_next = wr_data; // R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      value_reg <= RESET_VALUE; // R8
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule // pad_byte_reg
`default_nettype wire

// *** src/pad_gate.sv ***
/*
  Per-pin gating of pad settings by direction and ownership.
  Assumes ownership inputs are on the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_gate (
  input  wire logic pullup_bit,
  input  wire logic slew_bit,
  input  wire logic drive_bit,
  input  wire logic filter_bit,
  input  wire logic pin_direction,
  input  wire logic periph_drives,
  input  wire logic analog_owns,
  output logic      pullup_on,
  output logic      slew_limit_on,
  output logic      high_drive_on,
  output logic      filter_on
);
  logic is_output;

  // ==========================================================================
  // Gating
  // Analog ownership disables every digital setting, so it is checked first.
  assign is_output     = (pin_direction | periph_drives) & ~analog_owns; // R11
  assign pullup_on     = pullup_bit & ~is_output & ~analog_owns; // R1 R2 R9 R10
  assign slew_limit_on = slew_bit & is_output; // R3 R4
  assign high_drive_on = drive_bit & is_output; // R5
  assign filter_on     = filter_bit & ~analog_owns; // R6
endmodule // pad_gate
`default_nettype wire

// *** src/port_pin_pad_control.sv ***
/*
  Pad control for one 8-bit general-purpose port behind a classic Wishbone slave.
  Assumes direction and ownership inputs come from logic on core_clk; outputs feed the pad ring.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Each pin has a pull-up bit, 1 turns its pull-up on and 0 turns it off.
// R2: A pin set as output never has its pull-up on.
// R3: Each pin has a slew-limit bit, 1 enables slew limiting and 0 disables it.
// R4: On an input pin the slew-limit bit changes nothing.
// R5: Each pin has a drive bit, 0 selects low drive and 1 high drive.
// R6: Each pin has a filter bit, 1 enables its input low-pass filter and 0 disables it.
// R7: Filter bits are set by reset and only a software clear turns a filter off; filter_on is also held off while analog_owns is set.
// R8: Reset clears the pull-up, slew-limit and drive registers to zero.
// R9: A pin driven out by a peripheral never has its pull-up on.
// R10: A pin owned by an analog function never has its pull-up on.
// R11: Direction 0 makes a pin an input with driver off, 1 turns the driver on.
// R12: Each register reads back its last written value, all eight bits updated together.
module port_pin_pad_control #(
  parameter int unsigned PINS = pad_ctrl_pkg::PIN_COUNT
) (
  input  wire logic                                   core_clk,
  input  wire logic                                   rst,
  input  wire logic                                   clk_en,
  input  wire logic                                   wb_cyc_i,
  input  wire logic                                   wb_stb_i,
  input  wire logic                                   wb_we_i,
  input  wire logic [pad_ctrl_pkg::ADDR_WIDTH-1:0]    wb_adr_i,
  input  wire logic [pad_ctrl_pkg::SEL_WIDTH-1:0]     wb_sel_i,
  input  wire logic [pad_ctrl_pkg::DATA_WIDTH-1:0]    wb_dat_i,
  output logic      [pad_ctrl_pkg::DATA_WIDTH-1:0]    wb_dat_o,
  output logic                                        wb_ack_o,
  input  wire logic [PINS-1:0]                        pin_direction,
  input  wire logic [PINS-1:0]                        periph_drives,
  input  wire logic [PINS-1:0]                        analog_owns,
  output logic      [PINS-1:0]                        pullup_on,
  output logic      [PINS-1:0]                        slew_limit_on,
  output logic      [PINS-1:0]                        high_drive_on,
  output logic      [PINS-1:0]                        filter_on
);
  pad_ctrl_pkg::wb_req_t req;
  logic                  access;
  logic                  wr_lane0;
  logic                  hit_pullup;
  logic                  hit_slew;
  logic                  hit_drive;
  logic                  hit_filter;
  logic [PINS-1:0]       pullup_enable;
  logic [PINS-1:0]       slew_limit_enable;
  logic [PINS-1:0]       drive_strength_select;
  logic [PINS-1:0]       input_filter_enable;
  logic                  ack_reg;
  logic                  ack_next;
  logic [pad_ctrl_pkg::DATA_WIDTH-1:0] rdata_reg;
  logic [pad_ctrl_pkg::DATA_WIDTH-1:0] rdata_next;

  // ==========================================================================
  // Bus decode
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
  // A request is taken once; ack_reg blocks a second take while it is answered.
  assign access     = req.cyc & req.stb & ~ack_reg & clk_en;
  assign wr_lane0   = access & req.we & req.sel[0];
  assign hit_pullup = (req.adr == pad_ctrl_pkg::PULLUP_OFFSET);
  assign hit_slew   = (req.adr == pad_ctrl_pkg::SLEW_OFFSET);
  assign hit_drive  = (req.adr == pad_ctrl_pkg::DRIVE_OFFSET);
  assign hit_filter = (req.adr == pad_ctrl_pkg::FILTER_OFFSET);

  // ==========================================================================
  // Registers
  pad_byte_reg #(.WIDTH(PINS), .RESET_VALUE(pad_ctrl_pkg::PULLUP_RESET)) u_pullup (
    .core_clk (core_clk),
    .rst      (rst), // R8
    .wr_en    (wr_lane0 & hit_pullup), // R12
    .wr_data  (req.dat[PINS-1:0]),
    .value    (pullup_enable)
  );

  pad_byte_reg #(.WIDTH(PINS), .RESET_VALUE(pad_ctrl_pkg::SLEW_RESET)) u_slew (
    .core_clk (core_clk),
    .rst      (rst), // R8
    .wr_en    (wr_lane0 & hit_slew),
    .wr_data  (req.dat[PINS-1:0]),
    .value    (slew_limit_enable)
  );

  pad_byte_reg #(.WIDTH(PINS), .RESET_VALUE(pad_ctrl_pkg::DRIVE_RESET)) u_drive (
    .core_clk (core_clk),
    .rst      (rst), // R8
    .wr_en    (wr_lane0 & hit_drive),
    .wr_data  (req.dat[PINS-1:0]),
    .value    (drive_strength_select)
  );

  // Filters come out of reset enabled so a noisy pin is filtered before software runs.
  pad_byte_reg #(.WIDTH(PINS), .RESET_VALUE(pad_ctrl_pkg::FILTER_RESET)) u_filter (
    .core_clk (core_clk),
    .rst      (rst), // R7
    .wr_en    (wr_lane0 & hit_filter),
    .wr_data  (req.dat[PINS-1:0]),
    .value    (input_filter_enable)
  );

  // ==========================================================================
  // Acknowledge and read data
  always_comb begin
    ack_next   = ack_reg;
    rdata_next = rdata_reg;
    if (clk_en) begin
      ack_next = access;
      if (access & ~req.we) begin
        unique case (1'b1)
          hit_pullup: rdata_next = {{(pad_ctrl_pkg::DATA_WIDTH-PINS){1'b0}}, pullup_enable}; // R12
          hit_slew:   rdata_next = {{(pad_ctrl_pkg::DATA_WIDTH-PINS){1'b0}}, slew_limit_enable};
          hit_drive:  rdata_next = {{(pad_ctrl_pkg::DATA_WIDTH-PINS){1'b0}}, drive_strength_select};
          hit_filter: rdata_next = {{(pad_ctrl_pkg::DATA_WIDTH-PINS){1'b0}}, input_filter_enable};
          default:    rdata_next = pad_ctrl_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= pad_ctrl_pkg::UNMAPPED_DATA;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================================
  // Pad gating
  // The pad outputs are combinational from registers and core inputs; the pad ring
  // is expected to tolerate the settling of direction changes within one cycle.
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    pad_gate u_gate (
      .pullup_bit    (pullup_enable[i]), // R1 R2 R9 R10
      .slew_bit      (slew_limit_enable[i]), // R3 R4
      .drive_bit     (drive_strength_select[i]), // R5
      .filter_bit    (input_filter_enable[i]), // R6
      .pin_direction (pin_direction[i]), // R11
      .periph_drives (periph_drives[i]),
      .analog_owns   (analog_owns[i]),
      .pullup_on     (pullup_on[i]),
      .slew_limit_on (slew_limit_on[i]),
      .high_drive_on (high_drive_on[i]),
      .filter_on     (filter_on[i])
    );
  end
endmodule // port_pin_pad_control
`default_nettype wire

// *** test/pad_ctrl_monitor.sv ***
/* Port checks for port_pin_pad_control.
   Assumes one core_clk domain with synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module pad_ctrl_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  pin_direction,
  input wire logic [7:0]  periph_drives,
  input wire logic [7:0]  analog_owns,
  input wire logic [7:0]  pullup_on,
  input wire logic [7:0]  slew_limit_on,
  input wire logic [7:0]  high_drive_on,
  input wire logic [7:0]  filter_on
);
  // ==========================================================================
  // Bus and pad checks
  wire logic [7:0] out_pins = pin_direction | periph_drives;
  wire logic [7:0] wr_byte  = wb_dat_i[7:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o;
  endsequence
  sequence s_pullup_write;
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0);
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!wb_ack_o && !(wb_cyc_i && wb_stb_i && clk_en) |=> !wb_ack_o)
    else $error("ack without request");
  a_pullup_write: assert property (s_pullup_write |=>
    pullup_on == ($past(wr_byte) & ~out_pins & ~analog_owns)) else $error("pull-up not from written byte");
  a_pullup_gated: assert property ((pullup_on & (out_pins | analog_owns)) == 8'h00)
    else $error("pull-up on for driven or analog pin");
  a_input_no_drive: assert property (((slew_limit_on | high_drive_on) & ~out_pins) == 8'h00)
    else $error("drive setting on input pin");
  a_reset_values: assert property ($fell(rst) |-> !wb_ack_o && filter_on == ~analog_owns &&
    (pullup_on | slew_limit_on | high_drive_on) == 8'h00) else $error("wrong state after reset");
  a_unmapped_zero: assert property (s_take ##0 (!wb_we_i && wb_adr_i[1:0] != 2'h0) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_bus_frozen: assert property (!clk_en |=> $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("bus state moved while clock enable low");
  a_filter_analog: assert property ((filter_on & analog_owns) == 8'h00)
    else $error("filter on for analog pin");
endmodule // pad_ctrl_monitor
bind port_pin_pad_control pad_ctrl_monitor i_pad_ctrl_monitor (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_direction(pin_direction), .periph_drives(periph_drives),
  .analog_owns(analog_owns), .pullup_on(pullup_on), .slew_limit_on(slew_limit_on),
  .high_drive_on(high_drive_on), .filter_on(filter_on));
`default_nettype wire

// *** test/tb.sv ***
/* Self-checking bench for port_pin_pad_control.
   Assumes a 100 MHz core_clk and the one-cycle Wishbone answer. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // Signals and table: offset, data, direction, peripheral, analog, expected
  logic                   core_clk    = 1'b0;
  logic                   rst         = 1'b1;
  logic                   clk_en      = 1'b1;
  pad_ctrl_pkg::wb_req_t  req         = '0;
  logic [31:0]            rd;
  logic                   ack;
  logic [7:0]             dir         = 8'h00;
  logic [7:0]             per         = 8'h00;
  logic [7:0]             ana         = 8'h00;
  wire pad_ctrl_pkg::pad_ctrl_t pad;
  logic [31:0]            q;
  int                     error_cnt   = 0;
  int                     checks_done = 0;
  logic [7:0]             rows [6][6] = '{
    '{8'h00, 8'ha5, 8'h0f, 8'h10, 8'h01, 8'ha0}, '{8'h04, 8'h3c, 8'h0f, 8'h30, 8'h04, 8'h38},
    '{8'h08, 8'hff, 8'h81, 8'h00, 8'h00, 8'h81}, '{8'h0c, 8'h5a, 8'hff, 8'h00, 8'h40, 8'h1a},
    '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff}, '{8'h04, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00}};

  port_pin_pad_control i_port_pin_pad_control (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .pin_direction(dir), .periph_drives(per), .analog_owns(ana),
    .pullup_on(pad.pullup_on), .slew_limit_on(pad.slew_limit_on), .high_drive_on(pad.high_drive_on),
    .filter_on(pad.filter_on));

  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] pick(input logic [7:0] a);
    case (a)
      8'h00: return {24'h0, pad.pullup_on};
      8'h04: return {24'h0, pad.slew_limit_on};
      8'h08: return {24'h0, pad.high_drive_on};
      default: return {24'h0, pad.filter_on};
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The stall holds clk_en low under a live request; the slave must not take it.
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d, input int stall);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{1'b1, 1'b1, w, a, s, d};
    if (stall > 0) begin
      clk_en <= 1'b0;
      repeat (stall) @(posedge core_clk);
      chk({31'h0, ack}, 32'h0);
      clk_en <= 1'b1;
    end
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    q = rd;
    req <= '0;
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      {dir, per, ana} <= {rows[i][2], rows[i][3], rows[i][4]};
      wb(1'b1, rows[i][0][3:0], 4'h1, {24'h0, rows[i][1]}, 0);
      chk(pick(rows[i][0]), {24'h0, rows[i][5]});
      wb(1'b0, rows[i][0][3:0], 4'h1, 32'h0, 0);
      chk(q, {24'h0, rows[i][1]});
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, {k[1:0], 2'h0}, 4'h1, 32'h0, 0);
      chk(q, (k == 3) ? 32'hff : 32'h0);
    end
    chk({24'h0, pad.filter_on}, 32'hff);
    wb(1'b1, 4'h0, 4'he, 32'hff, 0);
    wb(1'b1, 4'h2, 4'hf, 32'hff, 0);
    wb(1'b0, 4'h0, 4'h1, 32'h0, 0);
    chk(q, 32'h0);
    wb(1'b0, 4'h2, 4'h1, 32'h0, 0);
    chk(q, 32'h0);
    dir <= 8'hf0;
    wb(1'b1, 4'h8, 4'h1, 32'h3c, 3);
    chk({24'h0, pad.high_drive_on}, 32'h30);
    wb(1'b0, 4'h8, 4'h1, 32'h0, 0);
    chk(q, 32'h3c);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
